// [rtl/audio_rec_ctrl.sv]
// audio record/playback controller: switches, buttons, sample buffer,
// codec master clock and an apb register slave with interrupt
// assumes a 250 MHz pclk and a codec that masters the serial clocks
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps

module audio_rec_ctrl #(
   parameter int unsigned BUF_DEPTH = audio_rec_pkg::BUF_DEPTH,
   parameter int unsigned DEBOUNCE_CYCLES = audio_rec_pkg::DEBOUNCE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic source_select_switch,
   input wire logic rate_select_bit0,
   input wire logic rate_select_bit1,
   input wire logic rate_select_bit2,
   input wire logic record_toggle_button,
   input wire logic play_toggle_button,
   input wire logic codec_bclk,
   input wire logic codec_lrclk,
   input wire logic codec_adc_data,
   output logic codec_dac_data,
   output logic codec_master_clock,
   output logic line_input_select,
   output audio_rec_pkg::rate_t rate_code,
   output logic recording,
   output logic playing
);
   localparam int unsigned AW = $clog2(BUF_DEPTH);
   localparam logic [AW:0] DEPTH_W = (AW + 1)'(BUF_DEPTH);
   localparam logic [31:0] DEB_LAST = 32'(DEBOUNCE_CYCLES - 1);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   if (BUF_DEPTH < 2 || DEBOUNCE_CYCLES < 1) begin : g_bad_param
      $error("buffer depth must be at least 2 and debounce at least 1");
   end

   function automatic audio_rec_pkg::rate_t rate_decode(input logic [2:0] sel);
      unique case (sel)
         3'h0: rate_decode = audio_rec_pkg::RATE_96K;
         3'h1: rate_decode = audio_rec_pkg::RATE_48K;
         3'h2: rate_decode = audio_rec_pkg::RATE_44K1;
         3'h3: rate_decode = audio_rec_pkg::RATE_32K;
         3'h4: rate_decode = audio_rec_pkg::RATE_8K;
         default: rate_decode = audio_rec_pkg::RATE_96K;
      endcase
   endfunction : rate_decode

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = a == audio_rec_pkg::ADDR_CTRL || a == audio_rec_pkg::ADDR_STATUS ||
         a == audio_rec_pkg::ADDR_LENGTH || a == audio_rec_pkg::ADDR_POSITION ||
         a == audio_rec_pkg::ADDR_IRQ_STATUS || a == audio_rec_pkg::ADDR_IRQ_ENABLE ||
         a == audio_rec_pkg::ADDR_IRQ_CLEAR;
   endfunction : addr_mapped

   // ----------------------------------------------------------------
   // switch and button synchronisers, button debounce
   // ----------------------------------------------------------------
   // bits: 0 source, 3:1 rate, 4 record button, 5 play button
   logic [5:0] pin_s1_q, pin_s2_q;
   logic [1:0] btn_lvl_q, btn_lvl_d, press;
   logic [31:0] btn_cnt_q [2];
   logic [31:0] btn_cnt_d [2];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         btn_lvl_d[i] = btn_lvl_q[i];
         btn_cnt_d[i] = 32'h0;
         // a level must hold for the whole debounce time to count
         if (pin_s2_q[4+i] != btn_lvl_q[i]) begin
            btn_cnt_d[i] = btn_cnt_q[i] + 32'h1;
            if (btn_cnt_q[i] == DEB_LAST) begin
               btn_lvl_d[i] = pin_s2_q[4+i];
               btn_cnt_d[i] = 32'h0;
            end
         end
      end
      press = btn_lvl_d & ~btn_lvl_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
         btn_lvl_q <= 2'h0;
         btn_cnt_q <= '{default: 32'h0};
      end else begin
         pin_s1_q <= {play_toggle_button, record_toggle_button, rate_select_bit2,
                      rate_select_bit1, rate_select_bit0, source_select_switch};
         pin_s2_q <= pin_s1_q;
         btn_lvl_q <= btn_lvl_d;
         btn_cnt_q <= btn_cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // serial port and sample buffer
   // ----------------------------------------------------------------
   audio_rec_pkg::frame_t rx_frame, tx_frame, rd_data_q;
   audio_rec_pkg::frame_t mem [BUF_DEPTH];
   logic rx_valid, tx_req, mem_we;
   logic [AW-1:0] wr_ptr_q, wr_ptr_d;
   logic [AW:0] rd_ptr_q, rd_ptr_d, rec_len_q, rec_len_d;
   audio_rec_pkg::mode_t mode_q, mode_d;

   i2s_slave_port u_port (
      .clk(pclk), .rst_n(presetn), .bclk_pin(codec_bclk), .lrclk_pin(codec_lrclk),
      .adc_pin(codec_adc_data), .tx_frame(tx_frame), .rx_frame(rx_frame),
      .rx_valid(rx_valid), .tx_req(tx_req), .dac_data(codec_dac_data)
   );

   // past the recorded length the player sends silence
   assign tx_frame = (mode_q == audio_rec_pkg::MODE_PLAY && rd_ptr_q != rec_len_q) ?
                     rd_data_q : '0;

   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[wr_ptr_q] <= rx_frame;
      end
      rd_data_q <= mem[rd_ptr_q[AW-1:0]];
   end

   // ----------------------------------------------------------------
   // control, registers and interrupt
   // ----------------------------------------------------------------
   logic line_sel_q, line_sel_d, pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
   logic rec_req, play_req, wr_take;
   logic [2:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d, ev;
   logic [31:0] prdata_q, prdata_d;
   audio_rec_pkg::rate_t rate_q, rate_d;
   logic [1:0] busy_q, busy_d;
   always_comb begin
      wr_take = psel & penable & pready_q & pwrite & addr_mapped(paddr);
      rec_req = press[0] |
                (wr_take && paddr == audio_rec_pkg::ADDR_CTRL && pwdata[audio_rec_pkg::CTRL_REC_BIT]);
      play_req = press[1] |
                 (wr_take && paddr == audio_rec_pkg::ADDR_CTRL && pwdata[audio_rec_pkg::CTRL_PLAY_BIT]);
      mode_d = mode_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      rec_len_d = rec_len_q;
      line_sel_d = line_sel_q;
      rate_d = rate_q;
      mem_we = 1'b0;
      ev = 3'h0;
      unique case (mode_q)
         audio_rec_pkg::MODE_IDLE: begin
            // record wins if both requests land in one cycle
            if (rec_req || play_req) begin
               line_sel_d = pin_s2_q[0];
               rate_d = rate_decode(pin_s2_q[3:1]);
            end
            if (rec_req) begin
               mode_d = audio_rec_pkg::MODE_RECORD;
               wr_ptr_d = '0;
            end else if (play_req) begin
               mode_d = audio_rec_pkg::MODE_PLAY;
               rd_ptr_d = '0;
            end
         end
         audio_rec_pkg::MODE_RECORD: begin
            if (rec_req) begin
               mode_d = audio_rec_pkg::MODE_IDLE;
               rec_len_d = {1'b0, wr_ptr_q};
               ev[audio_rec_pkg::IRQ_REC_END] = 1'b1;
            end else if (rx_valid) begin
               mem_we = 1'b1;
               wr_ptr_d = wr_ptr_q + 1'b1;
               if ({1'b0, wr_ptr_q} == DEPTH_W - 1'b1) begin
                  mode_d = audio_rec_pkg::MODE_IDLE;
                  rec_len_d = DEPTH_W;
                  ev[audio_rec_pkg::IRQ_REC_END] = 1'b1;
                  ev[audio_rec_pkg::IRQ_BUF_FULL] = 1'b1;
               end
            end
         end
         audio_rec_pkg::MODE_PLAY: begin
            if (play_req) begin
               mode_d = audio_rec_pkg::MODE_IDLE;
               ev[audio_rec_pkg::IRQ_PLAY_END] = 1'b1;
            end else if (tx_req) begin
               if (rd_ptr_q == rec_len_q) begin
                  mode_d = audio_rec_pkg::MODE_IDLE;
                  ev[audio_rec_pkg::IRQ_PLAY_END] = 1'b1;
               end else begin
                  rd_ptr_d = rd_ptr_q + 1'b1;
               end
            end
         end
         default: mode_d = audio_rec_pkg::MODE_IDLE;
      endcase

      // apb: one wait state, so every answer comes from a flip-flop
      pready_d = psel & penable & ~pready_q;
      pslverr_d = pready_d & ~addr_mapped(paddr);
      prdata_d = 32'h0;
      if (pready_d && !pwrite) begin
         unique case (paddr)
            audio_rec_pkg::ADDR_STATUS: begin
               prdata_d[audio_rec_pkg::ST_RECORDING] = mode_q == audio_rec_pkg::MODE_RECORD;
               prdata_d[audio_rec_pkg::ST_PLAYING] = mode_q == audio_rec_pkg::MODE_PLAY;
               prdata_d[audio_rec_pkg::ST_LINE_SEL] = line_sel_q;
               prdata_d[audio_rec_pkg::ST_RATE_LSB +: 3] = rate_q;
               prdata_d[audio_rec_pkg::ST_LIVE_SRC] = pin_s2_q[0];
               prdata_d[audio_rec_pkg::ST_LIVE_RATE_LSB +: 3] = pin_s2_q[3:1];
            end
            audio_rec_pkg::ADDR_LENGTH: prdata_d = 32'(rec_len_q);
            audio_rec_pkg::ADDR_POSITION:
               prdata_d = (mode_q == audio_rec_pkg::MODE_RECORD) ? 32'(wr_ptr_q) : 32'(rd_ptr_q);
            audio_rec_pkg::ADDR_IRQ_STATUS: prdata_d = 32'(irq_stat_q);
            audio_rec_pkg::ADDR_IRQ_ENABLE: prdata_d = 32'(irq_en_q);
            default: prdata_d = 32'h0;
         endcase
      end
      irq_en_d = irq_en_q;
      if (wr_take && paddr == audio_rec_pkg::ADDR_IRQ_ENABLE) begin
         irq_en_d = pwdata[2:0];
      end
      // a new event wins over a clear in the same cycle
      irq_stat_d = irq_stat_q | ev;
      if (wr_take && paddr == audio_rec_pkg::ADDR_IRQ_CLEAR) begin
         irq_stat_d = (irq_stat_q & ~pwdata[2:0]) | ev;
      end
      irq_d = |(irq_stat_d & irq_en_d);
      busy_d = {mode_d == audio_rec_pkg::MODE_PLAY, mode_d == audio_rec_pkg::MODE_RECORD};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= audio_rec_pkg::MODE_IDLE;
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         rec_len_q <= '0;
         line_sel_q <= 1'b0;
         rate_q <= audio_rec_pkg::RATE_96K;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
         irq_en_q <= audio_rec_pkg::IRQ_ENABLE_RST;
         irq_stat_q <= 3'h0;
         irq_q <= 1'b0;
         busy_q <= 2'h0;
      end else begin
         mode_q <= mode_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         rec_len_q <= rec_len_d;
         line_sel_q <= line_sel_d;
         rate_q <= rate_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         irq_en_q <= irq_en_d;
         irq_stat_q <= irq_stat_d;
         irq_q <= irq_d;
         busy_q <= busy_d;
      end
   end

   // ----------------------------------------------------------------
   // codec master clock
   // ----------------------------------------------------------------
   // fractional accumulator: mean rate just below target as the increment is truncated, edge jitter one pclk period
   logic [31:0] acc_q, acc_d;
   always_comb begin
      acc_d = acc_q + audio_rec_pkg::MCLK_INC;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 32'h0;
      end else begin
         acc_q <= acc_d;
      end
   end

   assign codec_master_clock = acc_q[31];
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign line_input_select = line_sel_q;
   assign rate_code = rate_q;
   assign recording = busy_q[0];
   assign playing = busy_q[1];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // helper: cycles since the last master clock rise, 0 until the first rise
   logic [4:0] mclk_gap_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mclk_gap_q <= 5'h00;
      end else if ($rose(acc_q[31])) begin
         mclk_gap_q <= 5'h01;
      end else if (mclk_gap_q != 5'h00 && mclk_gap_q != 5'h1F) begin
         mclk_gap_q <= mclk_gap_q + 5'h01;
      end
   end
   sequence start_s;
      mode_q == audio_rec_pkg::MODE_IDLE && (rec_req || play_req);
   endsequence

   src_latch_a: assert property (
      start_s |=> line_input_select == $past(pin_s2_q[0]))
      else $error("source select not taken from switch at start");
   rate_map_a: assert property (
      start_s |=> rate_code == rate_decode($past(pin_s2_q[3:1])))
      else $error("sample rate code does not match rate switches");
   rec_toggle_a: assert property (
      mode_q == audio_rec_pkg::MODE_RECORD && rec_req |=> !recording ##0 irq_stat_q[0])
      else $error("record press did not stop recording");
   play_start_a: assert property (
      mode_q == audio_rec_pkg::MODE_IDLE && play_req && !rec_req |=> playing && rd_ptr_q == 0)
      else $error("play press did not start playback");
   full_stop_a: assert property (
      mem_we && {1'b0, wr_ptr_q} == DEPTH_W - 1'b1 && !rec_req
      |=> !recording && rec_len_q == DEPTH_W && irq_stat_q[2])
      else $error("recording did not stop on full buffer");
   play_end_a: assert property (
      playing && tx_req && !play_req && rd_ptr_q == rec_len_q |=> !playing ##0 irq_stat_q[1])
      else $error("playback did not end after last sample");
   mclk_rate_a: assert property (
      $rose(acc_q[31]) && mclk_gap_q != 5'h00 |-> mclk_gap_q inside {5'h0D, 5'h0E})
      else $error("codec master clock period outside 13 to 14 cycles");
   settings_hold_a: assert property (
      mode_q != audio_rec_pkg::MODE_IDLE ##1 mode_q != audio_rec_pkg::MODE_IDLE
      |-> $stable(rate_q) && $stable(line_sel_q))
      else $error("settings changed during an operation");
   apb_wait_a: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not after exactly one wait state");

endmodule : audio_rec_ctrl

// [rtl/audio_rec_pkg.sv]
// shared constants and types for the audio record/playback controller
// assumes one 250 MHz system clock; the codec is the serial master
package audio_rec_pkg;

   // ----------------------------------------------------------------
   // clocks and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned MCLK_HZ = 18_432_000;
   // phase increment of the 32-bit accumulator that makes the codec master clock
   localparam logic [31:0] MCLK_INC = 32'((64'(MCLK_HZ) << 32) / 64'(CLK_HZ));
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);

   // ----------------------------------------------------------------
   // serial audio format and buffer
   // ----------------------------------------------------------------
   localparam int unsigned SAMPLE_BITS = 16;
   localparam int unsigned BUF_DEPTH = 16384;

   // ----------------------------------------------------------------
   // register map (byte addresses) and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LENGTH = 8'h08;
   localparam logic [7:0] ADDR_POSITION = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
   localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_REC_BIT = 0;
   localparam int unsigned CTRL_PLAY_BIT = 1;
   localparam int unsigned IRQ_REC_END = 0;
   localparam int unsigned IRQ_PLAY_END = 1;
   localparam int unsigned IRQ_BUF_FULL = 2;
   localparam int unsigned ST_RECORDING = 0;
   localparam int unsigned ST_PLAYING = 1;
   localparam int unsigned ST_LINE_SEL = 2;
   localparam int unsigned ST_RATE_LSB = 4;
   localparam int unsigned ST_LIVE_SRC = 8;
   localparam int unsigned ST_LIVE_RATE_LSB = 9;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {RATE_96K, RATE_48K, RATE_44K1, RATE_32K, RATE_8K} rate_t;
   typedef enum logic [1:0] {MODE_IDLE, MODE_RECORD, MODE_PLAY} mode_t;
   typedef struct packed {
      logic [SAMPLE_BITS-1:0] left;
      logic [SAMPLE_BITS-1:0] right;
   } frame_t;

endpackage : audio_rec_pkg

// [rtl/i2s_slave_port.sv]
// serial audio slave port: follows codec bit and channel clocks,
// deserialises converter samples and serialises playback samples
// assumes bit clock well below a quarter of the system clock
`timescale 1ns/1ps
module i2s_slave_port (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bclk_pin,
   input wire logic lrclk_pin,
   input wire logic adc_pin,
   input wire audio_rec_pkg::frame_t tx_frame,
   output audio_rec_pkg::frame_t rx_frame,
   output logic rx_valid,
   output logic tx_req,
   output logic dac_data
);
   localparam logic [4:0] WORD_LAST = 5'(audio_rec_pkg::SAMPLE_BITS - 1);
   localparam logic [4:0] WORD_DONE = 5'(audio_rec_pkg::SAMPLE_BITS);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] s1_q, s2_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
      end else begin
         s1_q <= {adc_pin, lrclk_pin, bclk_pin};
         s2_q <= s1_q;
      end
   end

   // ----------------------------------------------------------------
   // bit engine
   // ----------------------------------------------------------------
   logic bclk_last_q, lr_last_q, dac_q, valid_q, req_q;
   logic bclk_last_d, lr_last_d, dac_d, valid_d, req_d;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] rx_sh_q, rx_sh_d, left_q, left_d, tx_sh_q, tx_sh_d, right_q, right_d;
   audio_rec_pkg::frame_t frame_q, frame_d;
   logic rise, fall;

   always_comb begin
      rise = s2_q[0] & ~bclk_last_q;
      fall = ~s2_q[0] & bclk_last_q;
      bclk_last_d = s2_q[0];
      lr_last_d = lr_last_q;
      cnt_d = cnt_q;
      rx_sh_d = rx_sh_q;
      left_d = left_q;
      tx_sh_d = tx_sh_q;
      right_d = right_q;
      frame_d = frame_q;
      dac_d = dac_q;
      valid_d = 1'b0;
      req_d = 1'b0;
      if (rise) begin
         if (s2_q[1] != lr_last_q) begin
            // channel edge: this bit is the one-clock delay slot, msb follows
            lr_last_d = s2_q[1];
            cnt_d = 5'h00;
            if (!s2_q[1]) begin
               tx_sh_d = tx_frame.left;
               right_d = tx_frame.right;
               req_d = 1'b1;
            end else begin
               tx_sh_d = right_q;
            end
         end else if (cnt_q < WORD_DONE) begin
            rx_sh_d = {rx_sh_q[14:0], s2_q[2]};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == WORD_LAST) begin
               if (!lr_last_q) begin
                  left_d = rx_sh_d;
               end else begin
                  frame_d = '{left: left_q, right: rx_sh_d};
                  valid_d = 1'b1;
               end
            end
         end
      end
      // codec samples on the rising edge, so data moves on the falling one
      if (fall) begin
         dac_d = tx_sh_q[15];
         tx_sh_d = {tx_sh_d[14:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_last_q <= 1'b0;
         lr_last_q <= 1'b0;
         cnt_q <= WORD_DONE;
         rx_sh_q <= 16'h0000;
         left_q <= 16'h0000;
         tx_sh_q <= 16'h0000;
         right_q <= 16'h0000;
         frame_q <= '0;
         dac_q <= 1'b0;
         valid_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         bclk_last_q <= bclk_last_d;
         lr_last_q <= lr_last_d;
         cnt_q <= cnt_d;
         rx_sh_q <= rx_sh_d;
         left_q <= left_d;
         tx_sh_q <= tx_sh_d;
         right_q <= right_d;
         frame_q <= frame_d;
         dac_q <= dac_d;
         valid_q <= valid_d;
         req_q <= req_d;
      end
   end

   assign rx_frame = frame_q;
   assign rx_valid = valid_q;
   assign tx_req = req_q;
   assign dac_data = dac_q;

   word_length_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      valid_q |-> $past(cnt_q) == WORD_LAST && lr_last_q)
      else $error("stereo frame completed off the sixteenth bit");

endmodule : i2s_slave_port

// [verif/codec_model.sv]
// behavioural codec that masters the serial clocks and sends fixed words
// assumes bclk and lrclk stand still while run is low
`timescale 1ns/1ps
module codec_model #(
   parameter logic [15:0] LEFT_WORD = 16'hA5C3,
   parameter logic [15:0] RIGHT_WORD = 16'h3C5A
) (
   input wire logic run,
   input wire logic dac_data,
   output logic bclk,
   output logic lrclk,
   output logic adc_data,
   output logic heard_left
);
   logic [15:0] cap;
   logic [15:0] w;
   int i;
   int ch;
   initial begin
      bclk = 1'b0;
      lrclk = 1'b0;
      adc_data = 1'b0;
      heard_left = 1'b0;
      cap = 16'h0;
      forever begin
         // released data line toggles so a stale bit never looks valid
         if (!run) begin
            #40 adc_data = ~adc_data;
         end else for (ch = 0; ch < 2; ch++) begin
            w = (ch == 1) ? RIGHT_WORD : LEFT_WORD;
            for (i = 0; i < 18; i++) begin
               bclk = 1'b0;
               if (i == 0) lrclk = ch[0];
               adc_data = (i >= 1 && i <= 16) ? w[16-i] : ~adc_data;
               #20 bclk = 1'b1;
               if (i >= 1 && i <= 16) cap[16-i] = dac_data;
               #20;
            end
            if (ch == 0 && cap == LEFT_WORD) heard_left = 1'b1;
         end
      end
   end
endmodule : codec_model

// [verif/testbench.sv]
// self-checking bench for the audio record/playback controller
// assumes short debounce and an eight-frame buffer
`timescale 1ns/1ps
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic src = 0, r0 = 0, r1 = 0, r2 = 0, rec_btn = 0, play_btn = 0, err;
   logic [31:0] prdata;
   logic pready, pslverr, irq, bclk, lrclk, adc, dac, mclk, line_sel, recording, playing, heard;
   audio_rec_pkg::rate_t rate_code;
   int bad_count = 0, tests_run = 0, n_mclk = 0;
   logic last_mclk = 0;
   audio_rec_ctrl #(.BUF_DEPTH(8), .DEBOUNCE_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .source_select_switch(src), .rate_select_bit0(r0), .rate_select_bit1(r1),
      .rate_select_bit2(r2), .record_toggle_button(rec_btn), .play_toggle_button(play_btn),
      .codec_bclk(bclk), .codec_lrclk(lrclk), .codec_adc_data(adc), .codec_dac_data(dac),
      .codec_master_clock(mclk), .line_input_select(line_sel), .rate_code(rate_code),
      .recording(recording), .playing(playing));
   codec_model codec (.run(run), .dac_data(dac), .bclk(bclk), .lrclk(lrclk), .adc_data(adc),
      .heard_left(heard));
   initial begin
      forever #2 pclk = ~pclk;
   end
   task results;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 50) begin
         bad_count++;
         results();
      end
   endtask : apb
   task press(input bit rec);
      if (rec) rec_btn <= 1;
      else play_btn <= 1;
      repeat (12) @(posedge pclk);
      rec_btn <= 0;
      play_btn <= 0;
   endtask : press
   task await(input bit rec, input logic lvl);
      int n;
      for (n = 0; n < 40000 && (rec ? recording : playing) !== lvl; n++) @(posedge pclk);
      if (n >= 40000) begin
         bad_count++;
         results();
      end
   endtask : await
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      apb(0, audio_rec_pkg::ADDR_IRQ_ENABLE, 0);
      chk(rd, 32'h0);
      apb(0, 8'h40, 0);
      chk({err, rd}, {1'b1, 32'h0});
      $display("test reset and map done");
      // ------------------------------------------------------------
      // every rate code, alternating source, switches moved mid-run
      // ------------------------------------------------------------
      for (int k = 0; k < 8; k++) begin
         {r2, r1, r0} <= k[2:0];
         src <= k[0];
         repeat (4) @(posedge pclk);
         apb(1, audio_rec_pkg::ADDR_CTRL, 32'h1);
         repeat (2) @(posedge pclk);
         chk({31'h0, recording}, 32'h1);
         chk({29'h0, rate_code}, (k < 5) ? k : 0);
         chk({31'h0, line_sel}, k & 1);
         {r2, r1, r0} <= ~k[2:0];
         src <= ~k[0];
         repeat (4) @(posedge pclk);
         chk({28'h0, rate_code, line_sel}, {((k < 5) ? k[3:0] : 4'h0), k[0]});
         apb(1, audio_rec_pkg::ADDR_CTRL, 32'h1);
         repeat (2) @(posedge pclk);
         chk({31'h0, recording}, 32'h0);
      end
      $display("test rates done");
      apb(1, audio_rec_pkg::ADDR_IRQ_CLEAR, 32'h7);
      apb(1, audio_rec_pkg::ADDR_IRQ_ENABLE, 32'h7);
      run <= 1;
      press(1);
      await(1, 1);
      await(1, 0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(0, audio_rec_pkg::ADDR_IRQ_STATUS, 0);
      chk(rd, 32'h5);
      apb(0, audio_rec_pkg::ADDR_LENGTH, 0);
      chk(rd, 32'h8);
      apb(1, audio_rec_pkg::ADDR_IRQ_CLEAR, 32'h5);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      $display("test record to full done");
      press(0);
      await(0, 1);
      await(0, 0);
      apb(0, audio_rec_pkg::ADDR_IRQ_STATUS, 0);
      chk(rd, 32'h2);
      chk({31'h0, heard}, 32'h1);
      $display("test playback done");
      // 1000 pclk periods of 4 ns hold 73.7 periods of 18.432 MHz
      last_mclk = mclk;
      for (int c = 0; c < 1000; c++) begin
         @(posedge pclk);
         if (mclk === 1'b1 && last_mclk === 1'b0) n_mclk++;
         last_mclk = mclk;
      end
      chk({31'h0, n_mclk inside {73, 74}}, 32'h1);
      $display("test master clock done");
      results();
   end
endmodule : testbench
